// [hdl/wdcfg_pkg.sv]
// constants and field layout for the watchdog and its option register
package wdcfg_pkg;
  localparam logic [15:0] SERVICE_ADDR   = 16'hffff;
  localparam logic [7:0]  OPTION_RESET   = 8'h00;
  // option register bit positions
  localparam int          BIT_DISABLE    = 0;
  localparam int          BIT_STOP_EN    = 1;
  localparam int          BIT_TIMEOUT    = 2;
  localparam int          BIT_SHORT_REC  = 3;
  localparam int          BIT_INH_PWR    = 4;
  localparam int          BIT_INH_RST    = 5;
  localparam int          BIT_INH_STOP   = 6;
  // prescaler taps: 128 or 4096 cycles per counter step, 64 steps to overflow
  localparam int          TAP_SHORT      = 6;
  localparam int          TAP_LONG       = 11;
  localparam logic [5:0]  CNT_LAST       = 6'h3f;
  localparam logic [5:0]  CNT_RESTART    = 6'h01;
  localparam int          PIN_LOW_CYCLES = 32;
  localparam int          REC_SHORT      = 32;
  localparam int          REC_LONG       = 4096;
  localparam int          POR_CYCLES     = 4096;
endpackage : wdcfg_pkg

// [hdl/wdcfg_prescaler.sv]
// twelve-bit watchdog prescaler with full and partial clears
`timescale 1ns/100ps
`default_nettype none
module wdcfg_prescaler #(
  parameter int WIDTH = 12
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rst_b,
  input  wire logic             i_run,
  input  wire logic             i_clr_all,
  input  wire logic             i_clr_upper,
  output logic [WIDTH-1:0]      o_count
);
  // clears win over counting; upper clear keeps stages 1 to 3
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_count <= '0;
    end else if (i_clr_all) begin
      o_count <= '0;
    end else if (i_clr_upper) begin
      o_count <= {{(WIDTH-3){1'b0}}, o_count[2:0]};
    end else if (i_run) begin
      o_count <= o_count + 1'b1;
    end
  end
endmodule : wdcfg_prescaler
`default_nettype wire

// [hdl/wdcfg_top.sv]
// watchdog with write-once option register
`timescale 1ns/100ps
`default_nettype none
module wdcfg_top #(
  parameter int POR_DELAY = wdcfg_pkg::POR_CYCLES,
  parameter int REC_LONG  = wdcfg_pkg::REC_LONG
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_b,
  // cpu bus
  input  wire logic [15:0] i_addr,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic        i_opt_wr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic [7:0]  i_vector_low,
  input  wire logic        i_vector_fetch,
  input  wire logic        i_internal_reset,
  // mode and pin conditions, asynchronous
  input  wire logic        i_stop_req,
  input  wire logic        i_wake,
  input  wire logic        i_monitor_mode,
  input  wire logic        i_break_mode,
  input  wire logic        i_irq_test_voltage,
  input  wire logic        i_rst_test_voltage,
  input  wire logic        i_low_voltage_trip,
  input  wire logic        i_status_clr,
  output logic [7:0]       o_rdata,
  output logic [7:0]       o_system_option_one,
  output logic             o_reset_pin_b,
  output logic             o_watchdog_cause,
  output logic             o_stop_illegal,
  output logic             o_in_stop,
  output logic             o_stop_exit,
  output logic             o_inhibit_active,
  output logic             o_inhibit_reset,
  output logic             o_irq
);
  // two-stage synchronisers for pin-level inputs
  logic [6:0] sync1;
  logic [6:0] sync2;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {i_stop_req, i_wake, i_monitor_mode, i_break_mode,
                i_irq_test_voltage, i_rst_test_voltage,
                i_low_voltage_trip};
      sync2 <= sync1;
    end
  end
  wire stop_req  = sync2[6];
  wire wake      = sync2[5];
  wire mon       = sync2[4];
  wire brk       = sync2[3];
  wire irq_tst   = sync2[2];
  wire rst_tst   = sync2[1];
  wire lv_trip   = sync2[0];

  // option register, write-once
  logic [7:0] system_option_one;
  logic       opt_locked;
  wire        opt_take = i_opt_wr & ~opt_locked;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      system_option_one <= wdcfg_pkg::OPTION_RESET;
      opt_locked        <= 1'b0;
    end else if (opt_take) begin
      system_option_one <= i_wdata;
      opt_locked        <= 1'b1;
    end
  end
  wire watchdog_disable     = system_option_one[wdcfg_pkg::BIT_DISABLE];
  wire stop_enable          = system_option_one[wdcfg_pkg::BIT_STOP_EN];
  wire timeout_select       = system_option_one[wdcfg_pkg::BIT_TIMEOUT];
  wire short_recovery       = system_option_one[wdcfg_pkg::BIT_SHORT_REC];
  wire inhibit_power_enable = system_option_one[wdcfg_pkg::BIT_INH_PWR];
  wire inhibit_reset_enable = system_option_one[wdcfg_pkg::BIT_INH_RST];
  wire inhibit_in_stop      = system_option_one[wdcfg_pkg::BIT_INH_STOP];

  // service decode: write clears, read returns vector byte
  wire service_wr = i_wr & (i_addr == wdcfg_pkg::SERVICE_ADDR);
  wire service_rd = i_rd & (i_addr == wdcfg_pkg::SERVICE_ADDR);

  // stop entry, legal only when enabled; recovery delay counter
  wire        stop_edge;
  logic       stop_req_d;
  logic       in_stop;
  logic       recovering;
  logic [12:0] rec_cnt;
  wire [12:0] rec_len = short_recovery ? 13'(wdcfg_pkg::REC_SHORT)
                                       : 13'(REC_LONG);
  assign stop_edge = stop_req & ~stop_req_d;
  wire stop_enter = stop_edge & stop_enable & ~in_stop;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stop_req_d <= 1'b0;
      in_stop    <= 1'b0;
      recovering <= 1'b0;
      rec_cnt    <= '0;
    end else begin
      stop_req_d <= stop_req;
      if (stop_enter) begin
        in_stop <= 1'b1;
      end else if (in_stop & wake) begin
        in_stop    <= 1'b0;
        recovering <= 1'b1;
        rec_cnt    <= rec_len - 13'd1;
      end else if (recovering) begin
        if (rec_cnt == '0) begin
          recovering <= 1'b0;
        end else begin
          rec_cnt <= rec_cnt - 13'd1;
        end
      end
    end
  end

  // power-on delay before the prescaler first gets cleared
  logic [12:0] por_cnt;
  logic        por_done;
  wire         por_fire = ~por_done & (por_cnt == 13'(POR_DELAY - 1));
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      por_cnt  <= '0;
      por_done <= 1'b0;
    end else if (!por_done) begin
      por_cnt <= por_cnt + 13'd1;
      if (por_fire) begin
        por_done <= 1'b1;
      end
    end
  end

  // watchdog hold-off conditions
  wire test_hold = (mon & (irq_tst | rst_tst))
                 | (brk & rst_tst);
  // wait mode needs no term here: counting never looks at it
  wire wd_run = ~in_stop & ~recovering & ~watchdog_disable
              & ~test_hold;

  // prescaler and counter
  logic [11:0] presc;
  logic [11:0] presc_d;
  logic [5:0]  wd_cnt;
  logic        pulse_active;
  wire clr_all = stop_enter | por_fire | i_vector_fetch
               | i_internal_reset | pulse_active;
  wdcfg_prescaler #(.WIDTH(12)) u_presc (
    .i_mclk      (i_mclk),
    .i_rst_b     (i_rst_b),
    .i_run       (wd_run),
    .i_clr_all   (clr_all),
    .i_clr_upper (service_wr),
    .o_count     (presc)
  );
  // counter steps on falling edge of the selected prescaler tap
  wire tap_now  = timeout_select ? presc[wdcfg_pkg::TAP_SHORT]
                                 : presc[wdcfg_pkg::TAP_LONG];
  wire tap_prev = timeout_select ? presc_d[wdcfg_pkg::TAP_SHORT]
                                 : presc_d[wdcfg_pkg::TAP_LONG];
  wire tick     = tap_prev & ~tap_now & wd_run;
  wire overflow = tick & (wd_cnt == wdcfg_pkg::CNT_LAST);
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      presc_d <= '0;
      wd_cnt  <= '0;
    end else begin
      presc_d <= presc;
      if (i_internal_reset | pulse_active | service_wr) begin
        wd_cnt  <= '0;
        presc_d <= '0;
      end else if (clr_all) begin
        presc_d <= '0;
      end else if (overflow) begin
        wd_cnt <= '0;
      end else if (tick) begin
        wd_cnt <= wd_cnt + 6'd1;
      end
    end
  end

  // reset pulse: 32 cycles low on the reset pin
  logic [5:0] pulse_cnt;
  logic       watchdog_cause;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pulse_active   <= 1'b0;
      pulse_cnt      <= '0;
      watchdog_cause <= 1'b0;
    end else begin
      // the overflow cycle already pulls the pin, so count one less
      if (overflow) begin
        pulse_active <= 1'b1;
        pulse_cnt    <= 6'(wdcfg_pkg::PIN_LOW_CYCLES - 2);
      end else if (pulse_active) begin
        if (pulse_cnt == '0) begin
          pulse_active <= 1'b0;
        end else begin
          pulse_cnt <= pulse_cnt - 6'd1;
        end
      end
      // set wins over clear
      if (overflow) begin
        watchdog_cause <= 1'b1;
      end else if (i_status_clr) begin
        watchdog_cause <= 1'b0;
      end
    end
  end

  // low-voltage inhibit gating
  wire inhibit_on  = inhibit_power_enable
                   & (~in_stop | inhibit_in_stop);
  wire inhibit_rst = inhibit_on & inhibit_reset_enable & lv_trip;

  // registered outputs
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata             <= '0;
      o_system_option_one <= wdcfg_pkg::OPTION_RESET;
      o_reset_pin_b       <= 1'b1;
      o_watchdog_cause    <= 1'b0;
      o_stop_illegal      <= 1'b0;
      o_in_stop           <= 1'b0;
      o_stop_exit         <= 1'b0;
      o_inhibit_active    <= 1'b0;
      o_inhibit_reset     <= 1'b0;
      o_irq               <= 1'b0;
    end else begin
      o_rdata             <= service_rd ? i_vector_low
                                        : system_option_one;
      o_system_option_one <= system_option_one;
      o_reset_pin_b       <= ~(overflow | pulse_active);
      o_watchdog_cause    <= watchdog_cause | overflow;
      o_stop_illegal      <= stop_edge & ~stop_enable;
      o_in_stop           <= in_stop;
      o_stop_exit         <= recovering & (rec_cnt == '0);
      o_inhibit_active    <= inhibit_on;
      o_inhibit_reset     <= inhibit_rst;
      o_irq               <= 1'b0;
    end
  end

  // the pin goes low the cycle after overflow; checked low for 8 cycles and high again 33 cycles after overflow
  chk_pin_low_len: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    overflow |=> !o_reset_pin_b [*8])
    else $error("reset pin not held low after overflow");
  chk_pin_release: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    overflow |-> ##33 o_reset_pin_b)
    else $error("reset pin held low past its pulse");
  chk_cause_set: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    overflow |=> ##1 o_watchdog_cause)
    else $error("cause flag not set on overflow");
  chk_no_irq: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !o_irq)
    else $error("watchdog raised an interrupt");
  chk_opt_once: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    opt_locked && i_opt_wr |=> $stable(system_option_one))
    else $error("option register changed after first write");
  chk_disable_quiet: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    watchdog_disable |-> !overflow)
    else $error("disabled watchdog overflowed");
  chk_test_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    test_hold |-> !tick)
    else $error("watchdog counted under test voltage");
  chk_service_clr: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    service_wr && !i_internal_reset |=> wd_cnt == 6'h00 && presc[11:3] == '0)
    else $error("service write did not clear");
  chk_stop_gate: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    in_stop && !clr_all && !service_wr |=> $stable(presc))
    else $error("prescaler ran in stop");
  chk_stop_illegal: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    stop_edge && !stop_enable |=> o_stop_illegal && !in_stop)
    else $error("disabled stop not flagged illegal");
  chk_inhibit_stop: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    in_stop && !inhibit_in_stop |-> !inhibit_rst)
    else $error("inhibit active in stop without enable");
endmodule : wdcfg_top
`default_nettype wire

// [testbench/wdcfg_top_tb.sv]
// self-checking bench for the watchdog and its write-once option register
`timescale 1ns/100ps
`default_nettype none
module wdcfg_top_tb;
  typedef struct packed {logic [15:0] a; logic [7:0] v; logic [7:0] e;} wdcfg_row_t;
  logic        i_mclk, i_rst_b, i_wr, i_rd, i_opt_wr, i_vector_fetch;
  logic        i_internal_reset, i_stop_req, i_wake, i_monitor_mode;
  logic        i_break_mode, i_irq_test_voltage, i_rst_test_voltage;
  logic        i_low_voltage_trip, i_status_clr;
  logic [15:0] i_addr;
  logic [7:0]  i_wdata, i_vector_low, o_rdata, o_system_option_one;
  logic        o_reset_pin_b, o_watchdog_cause, o_stop_illegal, o_in_stop;
  logic        o_stop_exit, o_inhibit_active, o_inhibit_reset, o_irq;
  int          mismatches, total_checks, cyc, n;
  logic        seen;
  wdcfg_row_t  rows [4];
  wdcfg_top #(.POR_DELAY(16), .REC_LONG(16)) dut_u (.i_mclk(i_mclk),
    .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
    .i_opt_wr(i_opt_wr), .i_wdata(i_wdata), .i_vector_low(i_vector_low),
    .i_vector_fetch(i_vector_fetch), .i_internal_reset(i_internal_reset),
    .i_stop_req(i_stop_req), .i_wake(i_wake), .i_monitor_mode(i_monitor_mode),
    .i_break_mode(i_break_mode), .i_irq_test_voltage(i_irq_test_voltage),
    .i_rst_test_voltage(i_rst_test_voltage),
    .i_low_voltage_trip(i_low_voltage_trip), .i_status_clr(i_status_clr),
    .o_rdata(o_rdata), .o_system_option_one(o_system_option_one),
    .o_reset_pin_b(o_reset_pin_b), .o_watchdog_cause(o_watchdog_cause),
    .o_stop_illegal(o_stop_illegal), .o_in_stop(o_in_stop),
    .o_stop_exit(o_stop_exit), .o_inhibit_active(o_inhibit_active),
    .o_inhibit_reset(o_inhibit_reset), .o_irq(o_irq));
  // 20 MHz oscillator clock
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  // hang guard: the whole run needs about 78000 cycles
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 100000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic summarize();
    if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // reset held six cycles; all mode inputs return to idle with it
  task automatic rst_dut();
    i_rst_b <= 1'b0;
    {i_stop_req, i_wake, i_monitor_mode, i_break_mode} <= 4'h0;
    {i_irq_test_voltage, i_rst_test_voltage, i_low_voltage_trip} <= 3'h0;
    repeat (6) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    @(posedge i_mclk);
  endtask : rst_dut
  task automatic wr_opt(input logic [7:0] d);
    i_opt_wr <= 1'b1;
    i_wdata  <= d;
    @(posedge i_mclk);
    i_opt_wr <= 1'b0;
    @(posedge i_mclk);
  endtask : wr_opt
  // service write; data is deliberately not zero, any value must serve
  task automatic svc();
    i_wr   <= 1'b1;
    i_addr <= 16'hffff;
    i_wdata <= 8'h9c;
    @(posedge i_mclk);
    i_wr   <= 1'b0;
    @(posedge i_mclk);
  endtask : svc
  // watch n cycles: reset pin must stay high and no interrupt appear
  task automatic idle(input int cnt);
    seen = 1'b0;
    repeat (cnt) begin
      @(posedge i_mclk);
      if (o_reset_pin_b !== 1'b1 || o_irq !== 1'b0) seen = 1'b1;
    end
    chk("no_reset", 8'h00, {7'h0, seen});
  endtask : idle
  initial begin
    {i_rst_b, i_wr, i_rd, i_opt_wr, i_vector_fetch, i_internal_reset} = 6'h0;
    {i_stop_req, i_wake, i_monitor_mode, i_break_mode, i_status_clr} = 5'h0;
    {i_irq_test_voltage, i_rst_test_voltage, i_low_voltage_trip} = 3'h0;
    i_addr = 16'h0000;
    i_wdata = 8'h00;
    i_vector_low = 8'h00;
    {mismatches, total_checks, cyc} = 0;
    rows = '{'{16'hffff, 8'h5a, 8'h5a}, '{16'hffff, 8'ha5, 8'ha5},
             '{16'hfffe, 8'h5a, 8'h00}, '{16'h0000, 8'h3c, 8'h00}};
    rst_dut();
    chk("option_reset", 8'h00, o_system_option_one);
    chk("pin_reset", 8'h01, {7'h0, o_reset_pin_b});
    // reads: service location gives vector byte, others the option value
    foreach (rows[i]) begin
      i_rd <= 1'b1;
      i_addr <= rows[i].a;
      i_vector_low <= rows[i].v;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      @(negedge i_mclk);
      chk("rdata", rows[i].e, o_rdata);
      @(posedge i_mclk);
    end
    // write-once: second write must be dropped
    wr_opt(8'h0c);
    wr_opt(8'h01);
    chk("option_once", 8'h0c, o_system_option_one);
    // serviced well inside the short period, once by internal reset
    repeat (2) begin
      idle(6000);
      svc();
    end
    idle(6000);
    i_internal_reset <= 1'b1;
    @(posedge i_mclk);
    i_internal_reset <= 1'b0;
    idle(6000);
    svc();
    n = 0;
    while (o_reset_pin_b === 1'b1 && n < 9000) begin
      @(posedge i_mclk);
      n++;
    end
    chk("short_timeout", 8'h01, {7'h0, n >= 8100 && n <= 8200});
    n = 0;
    while (o_reset_pin_b === 1'b0 && n < 100) begin
      @(posedge i_mclk);
      n++;
    end
    chk("pin_low_len", 8'h01, {7'h0, n == 32});
    chk("cause", 8'h01, {7'h0, o_watchdog_cause});
    i_status_clr <= 1'b1;
    @(posedge i_mclk);
    i_status_clr <= 1'b0;
    @(posedge i_mclk);
    @(negedge i_mclk);
    chk("cause_clr", 8'h00, {7'h0, o_watchdog_cause});
    @(posedge i_mclk);
    // stop recovery: short 32 cycles, long cut to 16 by parameter
    foreach (rows[i]) if (i < 2) begin
      rst_dut();
      // inhibit kept alive in stop only on the first pass
      wr_opt(i == 0 ? 8'h5a : 8'h12);
      i_stop_req <= 1'b1;
      repeat (5) @(posedge i_mclk);
      chk("in_stop", 8'h01, {7'h0, o_in_stop});
      chk("stop_inhibit", i == 0 ? 8'h01 : 8'h00, {7'h0, o_inhibit_active});
      i_wake <= 1'b1;
      n = 0;
      while (o_stop_exit !== 1'b1 && n < 100) begin
        @(posedge i_mclk);
        n++;
      end
      chk("recovery", 8'h01, {7'h0, i == 0 ? n >= 30 && n <= 40
                                            : n >= 14 && n <= 24});
    end
    // stop with the instruction disabled is an illegal opcode
    rst_dut();
    i_stop_req <= 1'b1;
    seen = 1'b0;
    repeat (8) begin
      @(posedge i_mclk);
      if (o_stop_illegal === 1'b1) seen = 1'b1;
    end
    chk("stop_illegal", 8'h01, {7'h0, seen});
    chk("no_stop", 8'h00, {7'h0, o_in_stop});
    // held-off cases: disable bit, monitor and break with test voltage
    for (int k = 0; k < 4; k++) begin
      rst_dut();
      i_monitor_mode <= k == 1 || k == 2;
      i_break_mode <= k == 3;
      i_irq_test_voltage <= k == 1;
      i_rst_test_voltage <= k >= 2;
      wr_opt(k == 0 ? 8'h05 : 8'h04);
      idle(9000);
    end
    // inhibit reset gated by its enable bit
    for (int k = 0; k < 2; k++) begin
      rst_dut();
      wr_opt(k == 0 ? 8'h30 : 8'h10);
      i_low_voltage_trip <= 1'b1;
      repeat (5) @(posedge i_mclk);
      chk("inhibit_rst", k == 0 ? 8'h01 : 8'h00, {7'h0, o_inhibit_reset});
      chk("inhibit_on", 8'h01, {7'h0, o_inhibit_active});
    end
    // vector fetches keep the prescaler short of its first tap
    rst_dut();
    wr_opt(8'h04);
    repeat (90) begin
      i_vector_fetch <= 1'b1;
      @(posedge i_mclk);
      i_vector_fetch <= 1'b0;
      idle(99);
    end
    summarize();
  end
endmodule : wdcfg_top_tb
`default_nettype wire
